// ===== logic/i2c_timing_pkg.sv
`default_nettype none
package i2c_timing_pkg;

   // Register map of the plain register port.
   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 8;
   localparam logic [7:0]  OFS_DIVIDER = 8'h00;
   localparam logic [7:0]  OFS_COMMAND = 8'h01;
   localparam logic [7:0]  OFS_MODE    = 8'h02;
   localparam logic [7:0]  OFS_STATUS  = 8'h03;
   localparam logic [7:0]  DIVIDER_RESET = 8'h00;

   // Divider field positions.
   localparam int FIRST_FACTOR_LSB  = 3;
   localparam int FIRST_FACTOR_W    = 2;
   localparam int SECOND_FACTOR_LSB = 0;
   localparam int SECOND_FACTOR_W   = 3;

   // Mode and status bit positions.
   localparam int MODE_SLAVE_EN  = 0;
   localparam int MODE_SLAVE_BIT = 1;
   localparam int STAT_BUSY      = 0;
   localparam int STAT_EMPTY     = 1;
   localparam int STAT_FULL      = 2;
   localparam int STAT_RX_BIT    = 3;
   localparam int STAT_START     = 4;
   localparam int STAT_STOP      = 5;
   localparam int STAT_OVERFLOW  = 6;
   localparam int STAT_BUS_BUSY  = 7;

   // Counter width, phase length offsets in machine cycles, and command queue depth.
   localparam int CNT_W       = 12;
   localparam int LOW_EXTRA   = 2;
   localparam int SETUP_EXTRA = 1;
   localparam int HOLD_LESS   = 1;
   localparam int FREE_EXTRA  = 4;
   localparam int FIFO_DEPTH  = 4;

   typedef enum logic [1:0] {
      OP_START   = 2'b00,
      OP_BIT     = 2'b01,
      OP_STOP    = 2'b10,
      OP_RESTART = 2'b11
   } op_t;

   typedef struct packed {
      op_t  op;
      logic bit_val;
   } command_t;

   localparam int CMD_W = $bits(command_t);

   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] write_data;
      logic              write_strobe;
      logic              read_strobe;
   } reg_request_t;

   typedef enum logic [3:0] {
      ST_IDLE        = 4'b0000,
      ST_START_SETUP = 4'b0001,
      ST_START_HOLD  = 4'b0010,
      ST_WAIT        = 4'b0011,
      ST_LOW         = 4'b0100,
      ST_HIGH        = 4'b0101,
      ST_STOP_LOW    = 4'b0110,
      ST_STOP_SETUP  = 4'b0111,
      ST_BUS_FREE    = 4'b1000,
      ST_RS_LOW      = 4'b1001
   } phase_t;

   typedef struct packed {
      logic [DATA_W-1:0] divider;
      logic              slave_en;
      logic              slave_bit;
      logic [DATA_W-1:0] read_data;
      phase_t            st;
      logic [CNT_W-1:0]  cnt;
      logic              scl_oe;
      logic              sda_oe;
      logic              pin_out;
      logic              rx_bit;
      logic [1:0]        scl_q;
      logic [1:0]        sda_q;
      logic              scl_f;
      logic              sda_f;
      logic              start_seen;
      logic              stop_seen;
      logic              overflow;
      logic              bus_busy;
      logic              slave_wait;
   } timing_state_t;

   // First factor per two-bit code.
   function automatic logic [CNT_W-1:0] first_factor(
      input logic [FIRST_FACTOR_W-1:0] code);
      case (code)
         2'h0:    first_factor = 12'h001;
         2'h1:    first_factor = 12'h005;
         2'h2:    first_factor = 12'h006;
         default: first_factor = 12'h008;
      endcase
   endfunction

   // Second factor per three-bit code.
   function automatic logic [CNT_W-1:0] second_factor(
      input logic [SECOND_FACTOR_W-1:0] code);
      case (code)
         3'h0:    second_factor = 12'h004;
         3'h1:    second_factor = 12'h008;
         3'h2:    second_factor = 12'h016;
         3'h3:    second_factor = 12'h026;
         3'h4:    second_factor = 12'h062;
         default: second_factor = 12'h004;
      endcase
   endfunction

   // Divider product from a control byte.
   function automatic logic [CNT_W-1:0] divider_product(
      input logic [DATA_W-1:0] ctrl);
      logic [2*CNT_W-1:0] full;
      full = first_factor(ctrl[FIRST_FACTOR_LSB +: FIRST_FACTOR_W])
           * second_factor(ctrl[SECOND_FACTOR_LSB +: SECOND_FACTOR_W]);
      divider_product = full[CNT_W-1:0];
   endfunction

endpackage
`default_nettype wire

// ===== logic/command_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module command_fifo
   #(parameter int WIDTH = 3,
     parameter int DEPTH = 4)
   (input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 count;
      logic [AW-1:0]               rd;
      logic [AW-1:0]               wr;
   } fifo_state_t;

   fifo_state_t s;
   fifo_state_t next_s;
   logic        push;
   logic        pop;

   // Honest flags straight from the occupancy count.
   assign in_ready  = (s.count != DEPTH[AW:0]);
   assign out_valid = (s.count != '0);
   assign out_data  = s.mem[s.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointers wrap naturally, so depth must be a power of two.
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wr] = in_data;
         next_s.wr        = s.wr + 1'b1;
      end
      if (pop) begin
         next_s.rd = s.rd + 1'b1;
      end
      if (push && !pop) begin
         next_s.count = s.count + 1'b1;
      end else if (pop && !push) begin
         next_s.count = s.count - 1'b1;
      end
   end

   // Storage is left alone at reset; only the bookkeeping is cleared.
   always_ff @(posedge clock) begin
      if (srst) begin
         s.count <= '0;
         s.rd    <= '0;
         s.wr    <= '0;
         s.mem   <= s.mem;
      end else begin
         s <= next_s;
      end
   end

endmodule // command_fifo
`default_nettype wire

// ===== logic/i2c_bus_timing_generator.sv
`timescale 1ns/1ns
`default_nettype none
//  Function
// - First factor from divider bits four, three.
// - Second factor from divider bits two..zero.
// - Clock high half product, low two more.
// - Restart setup one plus half product.
// - Stop setup one plus half product.
// - Start hold half product minus one; full product minus one for the pair (1,8).
// - Slave data held two, changed by three.
module i2c_bus_timing_generator
   import i2c_timing_pkg::*;
   (input  wire logic               clock,
    input  wire logic               srst,
    input  wire reg_request_t       request,
    output logic [DATA_W-1:0]       read_data,
    input  wire logic               serial_clock_pin_in,
    output logic                    serial_clock_pin_out,
    output logic                    serial_clock_pin_oe,
    input  wire logic               serial_data_pin_in,
    output logic                    serial_data_pin_out,
    output logic                    serial_data_pin_oe);

   timing_state_t    s;
   timing_state_t    next_s;
   logic [CNT_W-1:0] product;
   logic [CNT_W-1:0] half;
   logic [CNT_W-1:0] low_len;
   logic [CNT_W-1:0] setup_len;
   logic [CNT_W-1:0] hold_len;
   logic [CNT_W-1:0] free_len;
   logic             wr_div;
   logic             wr_cmd;
   logic             wr_mode;
   logic             wr_stat;
   logic             fifo_in_ready;
   logic             fifo_valid;
   logic             fifo_take;
   logic [CMD_W-1:0] fifo_word;
   command_t         cmd;
   logic             start_ev;
   logic             stop_ev;
   logic             slave_fall;
   logic             slave_active;
   logic             pair_1_8;

   // Phase lengths follow the divider register at all times.
   always_comb begin
      product   = divider_product(s.divider);
      half      = {1'b0, product[CNT_W-1:1]};
      low_len   = CNT_W'(half + LOW_EXTRA);
      setup_len = CNT_W'(half + SETUP_EXTRA);
      pair_1_8  = (first_factor(s.divider[FIRST_FACTOR_LSB +:
                     FIRST_FACTOR_W]) == 12'h001) &&
                  (second_factor(s.divider[SECOND_FACTOR_LSB +:
                     SECOND_FACTOR_W]) == 12'h008);
      // The pair (1,8) gets the long hold, as the fast case needs it.
      hold_len  = pair_1_8 ? CNT_W'(product - HOLD_LESS)
                           : CNT_W'(half - HOLD_LESS);
      free_len  = CNT_W'({product, 1'b0} + FREE_EXTRA);
   end

   // Register port decode.
   assign wr_div  = request.write_strobe && request.address == OFS_DIVIDER;
   assign wr_cmd  = request.write_strobe && request.address == OFS_COMMAND;
   assign wr_mode = request.write_strobe && request.address == OFS_MODE;
   assign wr_stat = request.write_strobe && request.address == OFS_STATUS;

   // Commands are only taken in the wait and idle phases, idle dropping all but a start, and
   // only once the running phase has counted out, or the queue would drain.
   assign cmd          = command_t'(fifo_word);
   assign slave_active = s.slave_en && s.st == ST_IDLE;
   assign fifo_take    = (s.cnt == '0) &&
                         ((s.st == ST_WAIT) ||
                          (s.st == ST_IDLE &&
                           !(cmd.op == OP_START && s.bus_busy)));

   command_fifo #(
      .WIDTH (CMD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .srst      (srst),
      .in_valid  (wr_cmd),
      .in_ready  (fifo_in_ready),
      .in_data   (request.write_data[CMD_W-1:0]),
      .out_valid (fifo_valid),
      .out_ready (fifo_take),
      .out_data  (fifo_word)
   );

   // Pin filter, condition detection, register file and phase machine.
   always_comb begin
      next_s           = s;
      next_s.read_data = '0;
      next_s.slave_wait = 1'b0;

      // A line level counts only after two equal samples.
      next_s.scl_q = {s.scl_q[0], serial_clock_pin_in};
      next_s.sda_q = {s.sda_q[0], serial_data_pin_in};
      if (s.scl_q[0] == s.scl_q[1]) begin
         next_s.scl_f = s.scl_q[0];
      end
      if (s.sda_q[0] == s.sda_q[1]) begin
         next_s.sda_f = s.sda_q[0];
      end
      start_ev = s.scl_f && next_s.scl_f && s.sda_f && !next_s.sda_f;
      stop_ev  = s.scl_f && next_s.scl_f && !s.sda_f && next_s.sda_f;

      // Read data stand only in the cycle after the strobe.
      if (request.read_strobe) begin
         case (request.address)
            OFS_DIVIDER: next_s.read_data = s.divider;
            OFS_MODE: begin
               next_s.read_data[MODE_SLAVE_EN]  = s.slave_en;
               next_s.read_data[MODE_SLAVE_BIT] = s.slave_bit;
            end
            OFS_STATUS: begin
               next_s.read_data[STAT_BUSY]     = (s.st != ST_IDLE) ||
                                                 fifo_valid;
               next_s.read_data[STAT_EMPTY]    = !fifo_valid;
               next_s.read_data[STAT_FULL]     = !fifo_in_ready;
               next_s.read_data[STAT_RX_BIT]   = s.rx_bit;
               next_s.read_data[STAT_START]    = s.start_seen;
               next_s.read_data[STAT_STOP]     = s.stop_seen;
               next_s.read_data[STAT_OVERFLOW] = s.overflow;
               next_s.read_data[STAT_BUS_BUSY] = s.bus_busy;
            end
            default: next_s.read_data = '0;
         endcase
      end

      if (wr_div) begin
         next_s.divider = request.write_data;
      end
      if (wr_mode) begin
         next_s.slave_en  = request.write_data[MODE_SLAVE_EN];
         next_s.slave_bit = request.write_data[MODE_SLAVE_BIT];
      end
      // Sticky flags clear on a written one; a new event wins the cycle.
      if (wr_stat) begin
         if (request.write_data[STAT_START]) next_s.start_seen = 1'b0;
         if (request.write_data[STAT_STOP]) next_s.stop_seen = 1'b0;
         if (request.write_data[STAT_OVERFLOW]) next_s.overflow = 1'b0;
      end
      if (start_ev) begin
         next_s.start_seen = 1'b1;
         next_s.bus_busy   = 1'b1;
      end
      if (stop_ev) begin
         next_s.stop_seen = 1'b1;
         next_s.bus_busy  = 1'b0;
      end
      if (wr_cmd && !fifo_in_ready) begin
         next_s.overflow = 1'b1;
      end

      // Slave transmit: raw fall seen, wait one, then change the bit.
      slave_fall = s.scl_q[1] && !s.scl_q[0];
      if (slave_fall && slave_active) begin
         next_s.slave_wait = 1'b1;
      end
      if (s.slave_wait && slave_active) begin
         next_s.sda_oe = !s.slave_bit;
      end else if (s.st == ST_IDLE && !s.slave_en) begin
         next_s.sda_oe = 1'b0;
      end

      // Each phase loads its length minus one and ends at zero.
      if (s.cnt != '0) begin
         next_s.cnt = s.cnt - 1'b1;
      end else begin
         case (s.st)
            ST_IDLE: begin
               if (fifo_valid && fifo_take && cmd.op == OP_START) begin
                  next_s.st     = ST_START_SETUP;
                  next_s.sda_oe = 1'b0;
                  next_s.scl_oe = 1'b0;
                  next_s.cnt    = CNT_W'(setup_len - 1'b1);
               end
            end
            ST_START_SETUP: begin
               next_s.st     = ST_START_HOLD;
               next_s.sda_oe = 1'b1;
               next_s.cnt    = CNT_W'(hold_len - 1'b1);
            end
            ST_START_HOLD: begin
               next_s.st     = ST_WAIT;
               next_s.scl_oe = 1'b1;
               next_s.cnt    = CNT_W'(low_len - 1'b1);
            end
            ST_WAIT: begin
               // The clock is held low until software queues more.
               if (fifo_valid) begin
                  case (cmd.op)
                     OP_BIT: begin
                        next_s.st     = ST_LOW;
                        next_s.sda_oe = !cmd.bit_val;
                        next_s.cnt    = CNT_W'(low_len - 1'b1);
                     end
                     OP_STOP: begin
                        next_s.st     = ST_STOP_LOW;
                        next_s.sda_oe = 1'b1;
                        next_s.cnt    = CNT_W'(low_len - 1'b1);
                     end
                     default: begin
                        next_s.st     = ST_RS_LOW;
                        next_s.sda_oe = 1'b0;
                        next_s.cnt    = CNT_W'(low_len - 1'b1);
                     end
                  endcase
               end
            end
            ST_LOW: begin
               next_s.st     = ST_HIGH;
               next_s.scl_oe = 1'b0;
               next_s.cnt    = CNT_W'(half - 1'b1);
            end
            ST_HIGH: begin
               next_s.st     = ST_WAIT;
               next_s.rx_bit = s.sda_f;
               next_s.scl_oe = 1'b1;
               next_s.cnt    = CNT_W'(low_len - 1'b1);
            end
            ST_RS_LOW: begin
               next_s.st     = ST_START_SETUP;
               next_s.scl_oe = 1'b0;
               next_s.cnt    = CNT_W'(setup_len - 1'b1);
            end
            ST_STOP_LOW: begin
               next_s.st     = ST_STOP_SETUP;
               next_s.scl_oe = 1'b0;
               next_s.cnt    = CNT_W'(setup_len - 1'b1);
            end
            ST_STOP_SETUP: begin
               next_s.st     = ST_BUS_FREE;
               next_s.sda_oe = 1'b0;
               next_s.cnt    = CNT_W'(free_len - 1'b1);
            end
            ST_BUS_FREE: begin
               next_s.st = ST_IDLE;
            end
            default: begin
               next_s.st     = ST_IDLE;
               next_s.scl_oe = 1'b0;
               next_s.sda_oe = 1'b0;
            end
         endcase
      end
   end

   // One register holds every piece of state but the queue and the run counters.
   always_ff @(posedge clock) begin
      if (srst) begin
         s         <= '0;
         s.divider <= DIVIDER_RESET;
         s.scl_q   <= 2'h3;
         s.sda_q   <= 2'h3;
         s.scl_f   <= 1'b1;
         s.sda_f   <= 1'b1;
         s.st      <= ST_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // Open-drain pins: the level driven is always low.
   assign read_data            = s.read_data;
   assign serial_clock_pin_out = s.pin_out;
   assign serial_clock_pin_oe  = s.scl_oe;
   assign serial_data_pin_out  = s.pin_out;
   assign serial_data_pin_oe   = s.sda_oe;

   // Run lengths of the current phase and of the clock drive level.
   logic [CNT_W-1:0] st_run;
   logic [CNT_W-1:0] scl_run;
   always_ff @(posedge clock) begin
      if (srst) begin
         st_run  <= 12'h001;
         scl_run <= 12'h001;
      end else begin
         st_run  <= (next_s.st != s.st) ? 12'h001 : CNT_W'(st_run + 1'b1);
         scl_run <= (next_s.scl_oe != s.scl_oe) ? 12'h001
                                                : CNT_W'(scl_run + 1'b1);
      end
   end

   a_divider_decode: assert property (@(posedge clock) disable iff (srst)
      wr_div |=> (s.divider == $past(request.write_data) &&
         product == divider_product($past(request.write_data))))
      else $error("divider product does not follow the written fields");

   a_high_length: assert property (@(posedge clock) disable iff (srst)
      ($past(s.st) == ST_HIGH && s.st != ST_HIGH) |->
         $past(st_run) == half)
      else $error("clock high phase has the wrong length");

   a_low_length: assert property (@(posedge clock) disable iff (srst)
      (!s.scl_oe && $past(s.scl_oe)) |-> $past(scl_run) >= low_len)
      else $error("clock low phase is too short");

   a_restart_setup: assert property (@(posedge clock) disable iff (srst)
      ($past(s.st) == ST_START_SETUP && s.st == ST_START_HOLD) |->
         ($past(st_run) == setup_len && s.sda_oe && !s.scl_oe))
      else $error("start setup length or data drop is wrong");

   a_stop_setup: assert property (@(posedge clock) disable iff (srst)
      ($past(s.st) == ST_STOP_SETUP && s.st == ST_BUS_FREE) |->
         ($past(st_run) == setup_len && !s.sda_oe && $past(s.sda_oe)))
      else $error("stop setup length or data release is wrong");

   a_start_hold: assert property (@(posedge clock) disable iff (srst)
      ($past(s.st) == ST_START_HOLD && s.st == ST_WAIT) |->
         ($past(st_run) == hold_len && s.scl_oe))
      else $error("start hold length is wrong");

   a_filter_glitch: assert property (@(posedge clock) disable iff (srst)
      $changed(s.sda_f) |-> $past(s.sda_q[0]) == $past(s.sda_q[1]))
      else $error("data filter took a single-cycle level");

   a_slave_hold: assert property (@(posedge clock) disable iff (srst)
      (slave_fall && slave_active && !wr_mode) |=> $stable(s.sda_oe)
         ##1 (s.sda_oe == !$past(s.slave_bit)))
      else $error("slave data changed too early or too late");

   a_phase_whole: assert property (@(posedge clock) disable iff (srst)
      (s.cnt != '0) |=> (s.st == $past(s.st) && s.cnt == $past(s.cnt) - 1'b1))
      else $error("phase ended before its count ran out");

   a_queue_held: assert property (@(posedge clock) disable iff (srst)
      (s.cnt != '0 && fifo_valid) |=> (fifo_valid && $stable(fifo_word)))
      else $error("command queue moved while a phase was counting");

   a_bus_free: assert property (@(posedge clock) disable iff (srst)
      ($past(s.st) == ST_BUS_FREE && s.st == ST_IDLE) |->
         $past(st_run) == free_len)
      else $error("bus free time has the wrong length");

endmodule // i2c_bus_timing_generator
`default_nettype wire

// ===== testbench/bus_far_end.sv
`timescale 1ns/1ns
`default_nettype none
// Far side of the bus: a remote master plus the two pull-up resistors.
module bus_far_end
   (input  wire logic clock,
    input  wire logic dev_scl_oe,
    input  wire logic dev_sda_oe,
    output logic      scl_wire,
    output logic      sda_wire);

   logic far_scl_oe;
   logic far_sda_oe;

   // Both lines are pulled up, so a line nobody pulls reads high.
   assign scl_wire = !(dev_scl_oe || far_scl_oe);
   assign sda_wire = !(dev_sda_oe || far_sda_oe);

   initial begin
      far_scl_oe = 1'b0;
      far_sda_oe = 1'b0;
   end

   // Set both line pulls after an edge and keep them for a number of cycles.
   task automatic hold_lines(input logic scl_low, input logic sda_low,
                             input int cycles);
      @(posedge clock);
      far_scl_oe <= scl_low;
      far_sda_oe <= sda_low;
      repeat (cycles - 1) @(posedge clock);
   endtask
endmodule // bus_far_end
`default_nettype wire

// ===== testbench/i2c_bus_timing_generator_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) begin samples_checked++; \
   if ((got) !== (exp)) begin miscompares++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module i2c_bus_timing_generator_tb;
   import i2c_timing_pkg::*;
   logic              clock;
   logic              srst;
   reg_request_t      request;
   logic [DATA_W-1:0] read_data;
   logic              scl_wire, sda_wire, scl_out, scl_oe, sda_out, sda_oe;
   logic [1:0]        last_oe;
   int                miscompares, samples_checked, cyc, half;
   int                ev_t[$];
   // Divider pairs allowed in standard and fast mode: (1,8), (1,22), (5,4).
   localparam logic [7:0] DIVS [3] = '{8'h01, 8'h02, 8'h08};
   localparam int         PROD [3] = '{8, 22, 20};
   localparam int         HOLD [3] = '{7, 10, 9};

   i2c_bus_timing_generator dut (.clock(clock), .srst(srst),
      .request(request), .read_data(read_data),
      .serial_clock_pin_in(scl_wire), .serial_clock_pin_out(scl_out),
      .serial_clock_pin_oe(scl_oe), .serial_data_pin_in(sda_wire),
      .serial_data_pin_out(sda_out), .serial_data_pin_oe(sda_oe));
   bus_far_end far (.clock(clock), .dev_scl_oe(scl_oe),
      .dev_sda_oe(sda_oe), .scl_wire(scl_wire), .sda_wire(sda_wire));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Timestamp every change of the pin drivers; phase lengths are deltas.
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if ({scl_oe, sda_oe} !== last_oe) begin
         ev_t.push_back(cyc);
         last_oe <= {scl_oe, sda_oe};
      end
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // One-cycle strobes; every access leaves one idle cycle behind it.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      request <= '{a, d, 1'b1, 1'b0};
      @(posedge clock);
      request <= '0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      request <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      request <= '0;
      #1 d = read_data;
   endtask

   task automatic expect_reg(input logic [7:0] a, input logic [7:0] mask,
                             input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      `CHECK(d & mask, exp)
   endtask

   // Poll a status bit; a bound that runs out ends the run as a failure.
   task automatic wait_flag(input int b, input logic v);
      logic [7:0] d;
      d = {8{~v}};
      for (int n = 0; n < 3000 && d[b] !== v; n++) rd(OFS_STATUS, d);
      `CHECK(d[b], v)
      if (d[b] !== v) end_of_test();
   endtask

   initial begin
      repeat (100000) @(posedge clock);
      miscompares++;
      end_of_test();
   end

   initial begin
      request = '0;
      srst = 1'b1;
      last_oe = 2'b00;
      cyc = 0;
      miscompares = 0;
      samples_checked = 0;
      repeat (10) @(posedge clock);
      srst <= 1'b0;
      // Reset contents, an unmapped place, and the two divider fields.
      expect_reg(OFS_DIVIDER, 8'hFF, DIVIDER_RESET);
      expect_reg(OFS_STATUS, 8'hF7, 8'h02);
      wr(8'h10, 8'h55);
      expect_reg(8'h10, 8'hFF, 8'h00);
      wr(OFS_DIVIDER, 8'h18);
      expect_reg(OFS_DIVIDER, 8'hFF, 8'h18);
      wr(OFS_DIVIDER, 8'h07);
      expect_reg(OFS_DIVIDER, 8'hFF, 8'h07);
      // Start, bit, restart, stop, then a second start right behind it.
      for (int i = 0; i < 3; i++) begin
         half = PROD[i] / 2;
         wr(OFS_DIVIDER, DIVS[i]);
         ev_t.delete();
         wr(OFS_COMMAND, 8'h00);
         wr(OFS_COMMAND, 8'h03);
         wr(OFS_COMMAND, 8'h06);
         wr(OFS_COMMAND, 8'h04);
         wait_flag(STAT_EMPTY, 1'b1);
         wr(OFS_COMMAND, 8'h00);
         wr(OFS_COMMAND, 8'h04);
         wait_flag(STAT_BUSY, 1'b0);
         `CHECK(ev_t[1] - ev_t[0], HOLD[i])
         `CHECK(ev_t[3] - ev_t[2], half + 2)
         `CHECK(ev_t[4] - ev_t[3], half)
         `CHECK(ev_t[6] - ev_t[5], half + 1)
         `CHECK(ev_t[7] - ev_t[6], HOLD[i])
         `CHECK(ev_t[9] - ev_t[8], half + 1)
         `CHECK(ev_t[10] - ev_t[9] >= 2 * PROD[i] + 4, 1'b1)
         expect_reg(OFS_STATUS, 8'h08, 8'h08);
      end
      // A slow divider lets the queue fill until a push is refused.
      wr(OFS_DIVIDER, 8'h04);
      wr(OFS_COMMAND, 8'h00);
      for (int k = 0; k < 5; k++) wr(OFS_COMMAND, 8'h03);
      expect_reg(OFS_STATUS, 8'h47, 8'h45);
      wr(OFS_STATUS, 8'h40);
      expect_reg(OFS_STATUS, 8'h40, 8'h00);
      wait_flag(STAT_EMPTY, 1'b1);
      wr(OFS_COMMAND, 8'h04);
      wait_flag(STAT_BUSY, 1'b0);
      // Slave transmit of a zero: data may move only three cycles after fall.
      wr(OFS_MODE, 8'h01);
      expect_reg(OFS_MODE, 8'hFF, 8'h01);
      far.hold_lines(1'b1, 1'b0, 1);
      repeat (2) @(posedge clock);
      #1 `CHECK(sda_oe, 1'b0)
      @(posedge clock);
      #1 `CHECK(sda_oe, 1'b1)
      far.hold_lines(1'b0, 1'b0, 1);
      wr(OFS_MODE, 8'h00);
      // Letting go of data with the clock high is a stop; let it register.
      repeat (4) @(posedge clock);
      // A one-cycle dip goes unseen; held conditions are flagged.
      wr(OFS_STATUS, 8'h30);
      expect_reg(OFS_STATUS, 8'h30, 8'h00);
      far.hold_lines(1'b0, 1'b1, 1);
      far.hold_lines(1'b0, 1'b0, 4);
      expect_reg(OFS_STATUS, 8'h30, 8'h00);
      far.hold_lines(1'b0, 1'b1, 3);
      expect_reg(OFS_STATUS, 8'h30, 8'h10);
      far.hold_lines(1'b0, 1'b0, 3);
      expect_reg(OFS_STATUS, 8'h30, 8'h30);
      end_of_test();
   end
endmodule // i2c_bus_timing_generator_tb
`default_nettype wire
